// File: tsc_map.svh
// register offsets, field positions, reset values and line constants
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH
// ----------------------------------------
// pages and word addresses
// ----------------------------------------
`define TSC_PAGE_MSG        4'h1
`define TSC_PAGE_SIG_LO     4'h5
`define TSC_PAGE_SIG_HI     4'h6
`define TSC_PAGE_CTL_LO     4'h7
`define TSC_PAGE_CTL_HI     4'h8
`define TSC_ADDR_MSG        5'h18
`define TSC_ADDR_BASE_BIT   4
`define TSC_HI_PAGE_SLOTS   8
`define TSC_HI_PAGE_FIRST   5'h10
// ----------------------------------------
// reset values
// ----------------------------------------
`define TSC_RST_SIG         4'h0
`define TSC_RST_CTL         8'h00
`define TSC_RST_MSG         8'h00
`define TSC_RST_PRBS        15'h7FFF
// ----------------------------------------
// signaling frames and bit positions
// ----------------------------------------
`define TSC_FRM_SNAP        5'h01
`define TSC_FRM_A           5'h06
`define TSC_FRM_B           5'h0C
`define TSC_FRM_C           5'h12
`define TSC_FRM_D           5'h18
`define TSC_BIT_A           3
`define TSC_BIT_B           2
`define TSC_BIT_C           1
`define TSC_BIT_D           0
`define TSC_ROB_BIT         0
`define TSC_LAST_SLOT       5'h17
// ----------------------------------------
// digital milliwatt sequence
// ----------------------------------------
`define TSC_MW_SEQ          64'h1E0B0B1E9E8B8B9E
`endif

// File: tsc_pkg.sv
// shared types of the transmit signaling and slot control block
package tsc_pkg;
  typedef struct packed {
    logic message_insert_enable;
    logic invert;
    logic remote_slot_loopback;
    logic local_slot_loopback;
    logic transmit_test_enable;
    logic receive_test_enable;
    logic serial_signaling_select;
    logic clear_channel;
  } tsc_slot_ctl_t;

  typedef struct packed {
    logic [4:0] slot;
    logic [7:0] data;
  } tsc_tx_word_t;
endpackage : tsc_pkg

// File: tsc_fifo.sv
// synchronous fifo with registered output stage
module tsc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  output logic [WIDTH-1:0]                out_data,
  input  wire logic                       out_ready,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two, at least 4");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             load;

  assign in_ready = (count != CW'(DEPTH));
  assign push     = in_valid & in_ready;
  assign load     = (count != '0) & (~out_valid | out_ready);
  assign level    = count;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (load) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + CW'(push) - CW'(load);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : tsc_fifo

// File: tsc_t1_tx_sig_slot.sv
// T1 transmit robbed-bit signaling and per time slot control
//
// Function
// - signaling words channels 1-16 page five, 17-24 page six
// - select high: host word; low: serial control stream
// - A bit sent in frame 6, bit 8
// - B bit sent in frame 12, bit 8
// - C, D in frames 18, 24 ESF only
// - 24 control-stream slots, one nibble each
// - upper nibble when select is one, else lower
// - slot control words slots 1-16, then 17-24
// - bit 7 sends message register instead of data
// - bit 6 inverts transmit input and receive output
// - bit 5 loops received slot into transmit slot
// - bit 4 loops transmit slot into receive output
// - bit 3 sends milliwatt or PRBS test signal
// - bit 2 tests output slot: milliwatt or detector
// - bit 0 suppresses robbed-bit signaling
`include "tsc_map.svh"

module tsc_t1_tx_sig_slot #(
  parameter int NUM_SLOTS  = 24,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        srst,
  // host microprocessor port
  input  wire logic        cpu_cs,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [3:0]  cpu_page,
  input  wire logic [4:0]  cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  output logic [7:0]       cpu_rdata,
  output logic             cpu_rvalid,
  // global controls from the framer
  input  wire logic        esf_mode,
  input  wire logic        upper_nibble_select,
  input  wire logic        milliwatt_pattern_select,
  // transmit slot stream from the system side
  input  wire logic        tx_slot_valid,
  output logic             tx_slot_ready,
  input  wire logic [4:0]  tx_slot_idx,
  input  wire logic [4:0]  tx_frame_idx,
  input  wire logic [7:0]  serial_data_input,
  input  wire logic [7:0]  serial_control_input,
  // toward the line
  output logic             line_tx_valid,
  input  wire logic        line_tx_ready,
  output logic [4:0]       line_tx_slot,
  output logic [7:0]       line_tx_data,
  // received slot stream from the line
  input  wire logic        rx_slot_valid,
  input  wire logic [4:0]  rx_slot_idx,
  input  wire logic [7:0]  line_rx_data,
  // toward the system side
  output logic             serial_out_valid,
  output logic [7:0]       serial_data_output,
  output logic [7:0]       prbs_err_count
);
  localparam int CW = $clog2(FIFO_DEPTH+1);

  if (NUM_SLOTS != 24) begin : g_chk
    $error("T1 carries exactly 24 slots");
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [3:0]  sig_word [NUM_SLOTS];
  logic [7:0]  slot_ctl [NUM_SLOTS];
  logic [7:0]  tx_msg;
  logic [3:0]  sig_snap [NUM_SLOTS];
  logic [7:0]  rx_store [NUM_SLOTS];
  logic [7:0]  tx_store [NUM_SLOTS];

  // ----------------------------------------
  // host address decode
  // ----------------------------------------
  logic [4:0]  cpu_idx;
  logic        cpu_in_range;
  logic        hit_sig;
  logic        hit_ctl;
  logic        hit_msg;

  always_comb begin
    cpu_idx      = {1'b0, cpu_addr[3:0]};
    cpu_in_range = cpu_addr[`TSC_ADDR_BASE_BIT];
    if (cpu_page == `TSC_PAGE_SIG_HI || cpu_page == `TSC_PAGE_CTL_HI) begin
      // upper page holds only eight words, the rest is unmapped
      cpu_idx      = `TSC_HI_PAGE_FIRST + {2'b00, cpu_addr[2:0]};
      cpu_in_range = cpu_addr[`TSC_ADDR_BASE_BIT] & (cpu_addr[3:0] < 4'(`TSC_HI_PAGE_SLOTS));
    end
  end

  assign hit_sig = cpu_in_range & (cpu_page == `TSC_PAGE_SIG_LO || cpu_page == `TSC_PAGE_SIG_HI);
  assign hit_ctl = cpu_in_range & (cpu_page == `TSC_PAGE_CTL_LO || cpu_page == `TSC_PAGE_CTL_HI);
  assign hit_msg = (cpu_page == `TSC_PAGE_MSG) & (cpu_addr == `TSC_ADDR_MSG);

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        sig_word[i] <= `TSC_RST_SIG;
        slot_ctl[i] <= `TSC_RST_CTL;
      end
      tx_msg <= `TSC_RST_MSG;
    end else if (cpu_cs && cpu_wr) begin
      if (hit_sig) begin
        sig_word[cpu_idx] <= cpu_wdata[3:0];
      end
      if (hit_ctl) begin
        slot_ctl[cpu_idx] <= cpu_wdata;
      end
      if (hit_msg) begin
        tx_msg <= cpu_wdata;
      end
    end
  end

  // unused upper bits of signaling words and unmapped words read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_rdata  <= 8'h00;
      cpu_rvalid <= 1'b0;
    end else begin
      cpu_rvalid <= cpu_cs & cpu_rd;
      if (cpu_cs && cpu_rd) begin
        if (hit_sig) begin
          cpu_rdata <= {4'h0, sig_word[cpu_idx]};
        end else if (hit_ctl) begin
          cpu_rdata <= slot_ctl[cpu_idx];
        end else if (hit_msg) begin
          cpu_rdata <= tx_msg;
        end else begin
          cpu_rdata <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------
  // test pattern helpers
  // ----------------------------------------
  function automatic logic [22:0] prbs_gen8(input logic [14:0] s);
    logic [7:0]  b;
    logic [14:0] st;
    logic        fb;
    b  = 8'h00;
    st = s;
    for (int i = 7; i >= 0; i--) begin
      fb   = st[14] ^ st[13];
      b[i] = fb;
      st   = {st[13:0], fb};
    end
    return {b, st};
  endfunction : prbs_gen8

  function automatic logic [15:0] prbs_chk8(input logic [14:0] s, input logic [7:0] r);
    logic [14:0] st;
    logic        bad;
    st  = s;
    bad = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bad = bad | (r[i] != (st[14] ^ st[13]));
      st  = {st[13:0], r[i]};
    end
    return {bad, st};
  endfunction : prbs_chk8

  logic [63:0] mw_seq;
  logic [2:0]  mw_ptr;
  logic [7:0]  mw_byte;
  logic [14:0] prbs_tx;
  logic [14:0] prbs_rx;
  logic [22:0] gen_out;
  logic [15:0] chk_out;

  assign mw_seq  = `TSC_MW_SEQ;
  assign mw_byte = mw_seq[8*(7-mw_ptr) +: 8];
  assign gen_out = prbs_gen8(prbs_tx);
  assign chk_out = prbs_chk8(prbs_rx, line_rx_data);

  // ----------------------------------------
  // transmit slot datapath
  // ----------------------------------------
  tsc_pkg::tsc_slot_ctl_t tctl;
  tsc_pkg::tsc_tx_word_t  tx_word;
  logic        fifo_in_ready;
  logic [CW-1:0] fifo_level;
  logic        tx_take;
  logic [3:0]  ser_nibble;
  logic [3:0]  sig_sel;
  logic [7:0]  tx_byte;
  logic        rob_frame;
  logic        rob_bit;

  assign tctl       = tsc_pkg::tsc_slot_ctl_t'(slot_ctl[tx_slot_idx]);
  assign tx_take    = tx_slot_valid & tx_slot_ready & fifo_in_ready;
  assign ser_nibble = upper_nibble_select ? serial_control_input[7:4]
                                          : serial_control_input[3:0];
  assign sig_sel    = tctl.serial_signaling_select ? sig_word[tx_slot_idx] : ser_nibble;

  always_comb begin
    rob_frame = 1'b0;
    rob_bit   = 1'b0;
    case (tx_frame_idx)
      `TSC_FRM_A: begin
        rob_frame = 1'b1;
        rob_bit   = sig_snap[tx_slot_idx][`TSC_BIT_A];
      end
      `TSC_FRM_B: begin
        rob_frame = 1'b1;
        rob_bit   = sig_snap[tx_slot_idx][`TSC_BIT_B];
      end
      `TSC_FRM_C: begin
        rob_frame = esf_mode;
        rob_bit   = sig_snap[tx_slot_idx][`TSC_BIT_C];
      end
      `TSC_FRM_D: begin
        rob_frame = esf_mode;
        rob_bit   = sig_snap[tx_slot_idx][`TSC_BIT_D];
      end
      default: begin
        rob_frame = 1'b0;
        rob_bit   = 1'b0;
      end
    endcase
  end

  // test beats message beats loopback; inversion only touches system data
  always_comb begin
    if (tctl.transmit_test_enable) begin
      tx_byte = milliwatt_pattern_select ? mw_byte : gen_out[22:15];
    end else if (tctl.message_insert_enable) begin
      tx_byte = tx_msg;
    end else if (tctl.remote_slot_loopback) begin
      tx_byte = rx_store[tx_slot_idx];
    end else if (tctl.invert) begin
      tx_byte = ~serial_data_input;
    end else begin
      tx_byte = serial_data_input;
    end
    if (rob_frame && !tctl.clear_channel) begin
      tx_byte[`TSC_ROB_BIT] = rob_bit;
    end
  end

  assign tx_word.slot = tx_slot_idx;
  assign tx_word.data = tx_byte;

  // snapshot at the first frame keeps one superframe consistent
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        sig_snap[i] <= `TSC_RST_SIG;
      end
    end else if (tx_take && tx_frame_idx == `TSC_FRM_SNAP) begin
      sig_snap[tx_slot_idx] <= sig_sel;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        tx_store[i] <= 8'h00;
      end
    end else if (tx_take) begin
      tx_store[tx_slot_idx] <= tx_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mw_ptr  <= 3'h0;
      prbs_tx <= `TSC_RST_PRBS;
    end else if (tx_take) begin
      if (tx_slot_idx == `TSC_LAST_SLOT) begin
        mw_ptr <= mw_ptr + 3'h1;
      end
      // shared generator: several test slots draw successive bytes
      if (tctl.transmit_test_enable && !milliwatt_pattern_select) begin
        prbs_tx <= gen_out[14:0];
      end
    end
  end

  // two free words cover the one-cycle lag of the registered ready
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_slot_ready <= 1'b0;
    end else begin
      tx_slot_ready <= (fifo_level <= CW'(FIFO_DEPTH - 2));
    end
  end

  tsc_fifo #(
    .WIDTH ($bits(tsc_pkg::tsc_tx_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (tx_take),
    .in_ready  (fifo_in_ready),
    .in_data   (tx_word),
    .out_valid (line_tx_valid),
    .out_data  ({line_tx_slot, line_tx_data}),
    .out_ready (line_tx_ready),
    .level     (fifo_level)
  );

  // ----------------------------------------
  // receive slot datapath
  // ----------------------------------------
  tsc_pkg::tsc_slot_ctl_t rctl;

  assign rctl = tsc_pkg::tsc_slot_ctl_t'(slot_ctl[rx_slot_idx]);

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        rx_store[i] <= 8'h00;
      end
    end else if (rx_slot_valid) begin
      rx_store[rx_slot_idx] <= line_rx_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      serial_out_valid   <= 1'b0;
      serial_data_output <= 8'h00;
    end else begin
      serial_out_valid <= rx_slot_valid;
      if (rx_slot_valid) begin
        if (rctl.receive_test_enable && milliwatt_pattern_select) begin
          serial_data_output <= mw_byte;
        end else if (rctl.local_slot_loopback) begin
          serial_data_output <= tx_store[rx_slot_idx];
        end else if (rctl.invert) begin
          serial_data_output <= ~line_rx_data;
        end else begin
          serial_data_output <= line_rx_data;
        end
      end
    end
  end

  // self-synchronising detector, counts errored bytes, saturates
  always_ff @(posedge clk) begin
    if (srst) begin
      prbs_rx        <= `TSC_RST_PRBS;
      prbs_err_count <= 8'h00;
    end else if (rx_slot_valid && rctl.receive_test_enable && !milliwatt_pattern_select) begin
      prbs_rx <= chk_out[14:0];
      if (chk_out[15] && prbs_err_count != 8'hFF) begin
        prbs_err_count <= prbs_err_count + 8'h01;
      end
    end
  end
endmodule : tsc_t1_tx_sig_slot

// File: tsc_chk.sv
// assertion checker bound to the signaling and slot control block
module tsc_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       cpu_cs,
  input wire logic       cpu_wr,
  input wire logic       cpu_rd,
  input wire logic [3:0] cpu_page,
  input wire logic [4:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic       cpu_rvalid,
  input wire logic       line_tx_valid,
  input wire logic       line_tx_ready,
  input wire logic [4:0] line_tx_slot,
  input wire logic [7:0] line_tx_data,
  input wire logic       rx_slot_valid,
  input wire logic       serial_out_valid,
  input wire logic [7:0] prbs_err_count
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic rd;
  assign rd = cpu_cs && cpu_rd;
  // ----
  // register port
  // ----
  property p_rd_answer;
    rd |=> cpu_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_sig_gap;
    rd && cpu_page == 4'h6 && cpu_addr > 5'h17 |=> cpu_rdata == 8'h00;
  endproperty
  a_sig_gap: assert property (p_sig_gap) else $error("gap read not zero");
  property p_sig_unused;
    rd && cpu_page == 4'h5 |=> cpu_rdata[7:4] == 4'h0;
  endproperty
  a_sig_unused: assert property (p_sig_unused) else $error("unused bits set");
  property p_msg_back;
    (cpu_cs && cpu_wr && cpu_page == 4'h1 && cpu_addr == 5'h18) ##1
    (rd && !cpu_wr && cpu_page == 4'h1 && cpu_addr == 5'h18) |=> cpu_rdata == $past(cpu_wdata, 2);
  endproperty
  a_msg_back: assert property (p_msg_back) else $error("message read back wrong");
  // ----
  // streams
  // ----
  property p_line_hold;
    line_tx_valid && !line_tx_ready |=> line_tx_valid && $stable(line_tx_slot) && $stable(line_tx_data);
  endproperty
  a_line_hold: assert property (p_line_hold) else $error("line byte dropped");
  property p_rx_answer;
    rx_slot_valid |=> serial_out_valid;
  endproperty
  a_rx_answer: assert property (p_rx_answer) else $error("rx slot not answered");
  property p_rx_cause;
    serial_out_valid |-> $past(rx_slot_valid);
  endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("spurious serial output");
  property p_err_sat;
    prbs_err_count == 8'hFF |=> prbs_err_count == 8'hFF;
  endproperty
  a_err_sat: assert property (p_err_sat) else $error("error count wrapped");
endmodule : tsc_chk

bind tsc_t1_tx_sig_slot tsc_chk tsc_chk_inst (.clk, .srst, .cpu_cs, .cpu_wr, .cpu_rd, .cpu_page, .cpu_addr,
  .cpu_wdata, .cpu_rdata, .cpu_rvalid, .line_tx_valid, .line_tx_ready, .line_tx_slot, .line_tx_data,
  .rx_slot_valid, .serial_out_valid, .prbs_err_count);

// File: tsc_line_sink.sv
// line side model draining the transmit stream with random stalls
module tsc_line_sink (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       stall,
  input  wire logic       line_tx_valid,
  input  wire logic [4:0] line_tx_slot,
  input  wire logic [7:0] line_tx_data,
  output logic            line_tx_ready,
  output logic            got,
  output logic [4:0]      got_slot,
  output logic [7:0]      got_data
);
  timeunit 1ns;
  timeprecision 1ns;
  integer seed = 32'hB15D;
  // ----
  // handshake capture
  // ----
  // a byte counts only where valid and ready met at one edge
  always @(posedge clk) begin
    got <= line_tx_valid && line_tx_ready && !srst;
    got_slot <= line_tx_slot;
    got_data <= line_tx_data;
    #1;
    line_tx_ready = !srst && !stall && ($random(seed) & 3) != 0;
  end
endmodule : tsc_line_sink

// File: tsc_t1_tx_sig_slot_test.sv
// self-checking bench of the signaling and slot control block
`include "tsc_map.svh"
module tsc_t1_tx_sig_slot_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEPTH = 8;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cpu_cs = 1'b0;
  logic        cpu_wr = 1'b0;
  logic        cpu_rd = 1'b0;
  logic [3:0]  cpu_page = 4'h0;
  logic [4:0]  cpu_addr = 5'h00;
  logic [7:0]  cpu_wdata = 8'h00;
  logic        esf_mode = 1'b1;
  logic        upper_nibble_select = 1'b0;
  logic        milliwatt_pattern_select = 1'b1;
  logic        tx_slot_valid = 1'b0;
  logic [4:0]  tx_slot_idx = 5'h00;
  logic [4:0]  tx_frame_idx = 5'h01;
  logic [7:0]  serial_data_input = 8'h00;
  logic [7:0]  serial_control_input = 8'h00;
  logic        rx_slot_valid = 1'b0;
  logic [4:0]  rx_slot_idx = 5'h00;
  logic [7:0]  line_rx_data = 8'h00;
  logic        stall = 1'b0;
  logic        cpu_rvalid, tx_slot_ready, line_tx_valid, line_tx_ready, serial_out_valid, got;
  logic [4:0]  line_tx_slot, got_slot;
  logic [7:0]  cpu_rdata, line_tx_data, serial_data_output, prbs_err_count, got_data, msg, v;
  logic [63:0] mwseq = `TSC_MW_SEQ;
  logic [12:0] q [$];
  logic [12:0] head;
  tsc_pkg::tsc_slot_ctl_t ctl [24];
  logic [3:0]  sig [24];
  logic [3:0]  snap [24];
  logic [7:0]  last_rx [24];
  logic [7:0]  last_tx [24];
  integer      seed = 32'hB15D;
  int          mw = 0;
  logic [14:0] pr = `TSC_RST_PRBS;
  int          mismatches = 0;
  int          n_tests = 0;
  int          i, f, n, sf;

  always #25 clk = ~clk;

  tsc_t1_tx_sig_slot #(.NUM_SLOTS(24), .FIFO_DEPTH(DEPTH)) tsc_t1_tx_sig_slot_inst (.clk, .srst, .cpu_cs,
    .cpu_wr, .cpu_rd, .cpu_page, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_rvalid, .esf_mode, .upper_nibble_select,
    .milliwatt_pattern_select, .tx_slot_valid, .tx_slot_ready, .tx_slot_idx, .tx_frame_idx, .serial_data_input,
    .serial_control_input, .line_tx_valid, .line_tx_ready, .line_tx_slot, .line_tx_data, .rx_slot_valid,
    .rx_slot_idx, .line_rx_data, .serial_out_valid, .serial_data_output, .prbs_err_count);
  tsc_line_sink tsc_line_sink_inst (.clk, .srst, .stall, .line_tx_valid, .line_tx_slot, .line_tx_data,
    .line_tx_ready, .got, .got_slot, .got_data);

  // ----
  // checking and bus tasks
  // ----
  task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
    n_tests++;
    if (got_v !== exp_v) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : check

  task automatic summarize();
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic timeout(input bit hit);
    if (hit) begin
      mismatches++;
      $display("Error at %0t: wait timed out", $time);
      summarize();
    end
  endtask : timeout

  // requests stay up after the take edge; idle releases them
  task automatic cpu(input logic wr, input logic [3:0] pg, input logic [4:0] ad, input logic [7:0] d);
    {cpu_cs, cpu_wr, cpu_rd, cpu_page, cpu_addr, cpu_wdata} = {1'b1, wr, !wr, pg, ad, d};
    @(posedge clk);
    #1;
    if (!wr) check({7'h00, cpu_rvalid}, 8'h01);
    if (!wr) check(cpu_rdata, d);
  endtask : cpu

  task automatic idle();
    {cpu_cs, cpu_wr, cpu_rd, tx_slot_valid, rx_slot_valid} = 5'h00;
    @(posedge clk);
    #1;
  endtask : idle

  task automatic put(input logic is_ctl, input logic [4:0] s, input logic [7:0] d);
    if (is_ctl) ctl[s] = d;
    else sig[s] = d[3:0];
    cpu(1'b1, (is_ctl ? 4'h7 : 4'h5) + {3'h0, s[4]}, {1'b1, s[3:0]}, d);
  endtask : put

  // expected line byte; updates snapshot, loop and milliwatt state
  function automatic logic [7:0] exp_tx(input logic [4:0] s, input logic [4:0] fr, input logic [7:0] d,
                                        input logic [7:0] c);
    logic [7:0] b;
    tsc_pkg::tsc_slot_ctl_t k;
    k = ctl[s];
    if (fr == 5'h01) snap[s] = k.serial_signaling_select ? sig[s] : (upper_nibble_select ? c[7:4] : c[3:0]);
    if (k.transmit_test_enable && milliwatt_pattern_select) b = mwseq[63 - 8 * mw -: 8];
    else if (k.transmit_test_enable) begin
      // 2^15-1 generator, x^15 + x^14 + 1, first bit sent is the msb
      for (int j = 7; j >= 0; j--) begin
        b[j] = pr[14] ^ pr[13];
        pr   = {pr[13:0], b[j]};
      end
    end
    else if (k.message_insert_enable) b = msg;
    else if (k.remote_slot_loopback) b = last_rx[s];
    else b = d ^ {8{k.invert}};
    if (!k.clear_channel && (fr == 5'h06 || fr == 5'h0C || esf_mode && (fr == 5'h12 || fr == 5'h18)))
      b[0] = snap[s][fr == 5'h06 ? 3 : fr == 5'h0C ? 2 : fr == 5'h12 ? 1 : 0];
    last_tx[s] = b;
    if (s == 5'h17) mw = (mw + 1) % 8;
    return b;
  endfunction : exp_tx

  task automatic send(input logic [4:0] s, input logic [4:0] fr, input logic [7:0] d, input logic [7:0] c);
    int   k;
    logic rdy;
    {tx_slot_valid, tx_slot_idx, tx_frame_idx, serial_data_input, serial_control_input} = {1'b1, s, fr, d, c};
    k = 0;
    // ready is read between edges, where it is settled for the coming edge
    do begin
      rdy = tx_slot_ready;
      @(posedge clk);
      #1;
      k++;
    end while (rdy !== 1'b1 && k < 500);
    timeout(rdy !== 1'b1);
    q.push_back({s, exp_tx(s, fr, d, c)});
  endtask : send

  task automatic drain();
    tx_slot_valid = 1'b0;
    for (n = 0; n < 3000 && q.size() != 0; n++) @(posedge clk);
    timeout(q.size() != 0);
    @(posedge clk);
    #1;
  endtask : drain

  task automatic recv(input logic [4:0] s, input logic [7:0] d);
    logic [7:0] e;
    e = d ^ {8{ctl[s].invert}};
    if (ctl[s].local_slot_loopback) e = last_tx[s];
    if (ctl[s].receive_test_enable && milliwatt_pattern_select) e = mwseq[63 - 8 * mw -: 8];
    last_rx[s] = d;
    {rx_slot_valid, rx_slot_idx, line_rx_data} = {1'b1, s, d};
    @(posedge clk);
    #1;
    check({7'h00, serial_out_valid}, 8'h01);
    check(serial_data_output, e);
  endtask : recv

  always @(posedge clk) begin
    if (got === 1'b1) begin
      head = (q.size() != 0) ? q.pop_front() : 13'h1FFF;
      check({3'h0, got_slot}, {3'h0, head[12:8]});
      check(got_data, head[7:0]);
    end
  end

  // ----
  // scenarios
  // ----
  initial begin
    foreach (ctl[j]) {ctl[j], sig[j], snap[j], last_rx[j], last_tx[j]} = '0;
    msg = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    for (i = 0; i < 24; i++) begin
      v = 8'($random(seed));
      put(1'b0, i[4:0], v);
      cpu(1'b0, 4'h5 + {3'h0, i[4]}, {1'b1, i[3:0]}, {4'h0, v[3:0]});
      v = 8'($random(seed));
      put(1'b1, i[4:0], v);
      cpu(1'b0, 4'h7 + {3'h0, i[4]}, {1'b1, i[3:0]}, v);
    end
    for (i = 24; i < 32; i++) begin
      cpu(1'b1, 4'h6, i[4:0], 8'hFF);
      cpu(1'b0, 4'h6, i[4:0], 8'h00);
      cpu(1'b1, 4'h8, i[4:0], 8'hFF);
      cpu(1'b0, 4'h8, i[4:0], 8'h00);
    end
    msg = 8'($random(seed));
    cpu(1'b1, 4'h1, 5'h18, msg);
    cpu(1'b0, 4'h1, 5'h18, msg);
    idle();
    // random traffic, D4 and ESF, both nibbles, words rewritten mid-superframe
    for (sf = 0; sf < 4; sf++) begin
      esf_mode = sf[0];
      upper_nibble_select = sf[1];
      for (f = 1; f <= (esf_mode ? 24 : 12); f++) begin
        if (f == 3) begin
          idle();
          for (i = 0; i < 24; i += 5) put(1'b0, i[4:0], 8'($random(seed)));
          for (i = 2; i < 24; i += 5) put(1'b1, i[4:0], 8'($random(seed)));
          idle();
        end
        for (i = 0; i < 24; i++) send(i[4:0], f[4:0], 8'($random(seed)), 8'($random(seed)));
        drain();
        for (i = 0; i < 24; i++) recv(i[4:0], 8'($random(seed)));
        idle();
      end
    end
    // line stalls: fill until refused, hold, then drain in order
    stall = 1'b1;
    idle();
    i = 0;
    while (tx_slot_ready === 1'b1 && i < 20) begin
      send(i[4:0], 5'h02, 8'($random(seed)), 8'h00);
      i++;
    end
    tx_slot_valid = 1'b0;
    check({7'h00, i >= DEPTH - 1 && i <= DEPTH + 1}, 8'h01);
    repeat (10) @(posedge clk);
    #1;
    check({7'h00, tx_slot_ready}, 8'h00);
    check(8'(q.size()), 8'(i));
    stall = 1'b0;
    drain();
    // detector fed with noise saturates its error count
    // generator looped into the detector counts no errors
    milliwatt_pattern_select = 1'b0;
    put(1'b1, 5'h00, 8'h0C);
    idle();
    for (i = 0; i < 20; i++) begin
      send(5'h00, 5'h02, 8'($random(seed)), 8'h00);
      drain();
      recv(5'h00, last_tx[0]);
      idle();
    end
    check(prbs_err_count, 8'h00);
    for (i = 0; i < 300; i++) recv(5'h00, 8'($random(seed)));
    idle();
    repeat (4) @(posedge clk);
    #1;
    check(prbs_err_count, 8'hFF);
    summarize();
  end
endmodule : tsc_t1_tx_sig_slot_test
